// [rtl/eacsd_defines.svh]
/*
 Constants for the extended address and emulation chip select decoder.
 Assumes inclusion by bare name from the decoder files.
*/
`ifndef EACSD_DEFINES_SVH
`define EACSD_DEFINES_SVH

`define EACSD_REGION_HI 15
`define EACSD_REGION_LO 14
`define EACSD_XA_LOW 6'h3d
`define EACSD_XA_MID 6'h3e
`define EACSD_XA_TOP 6'h3f
`define EACSD_PIX_SW00 6'h38
`define EACSD_PIX_SW01 6'h30
`define EACSD_PIX_SW10 6'h20
`define EACSD_CS_BIT 7
`define EACSD_PORTK_W 8
`define EACSD_XA_W 6
`define EACSD_PORTK_RST 8'h00
`define EACSD_PORTK_OE_RST 8'h00

`endif

// [rtl/eacsd_pkg.sv]
/*
 Types for the extended address and emulation chip select decoder.
 Assumes nothing of its surroundings.
*/
package eacsd_pkg;
    // Physical 16K region of the CPU address
    typedef enum logic [1:0] {
        EACSD_REG_LOW,
        EACSD_REG_MID,
        EACSD_REG_WIN,
        EACSD_REG_TOP
    } eacsd_region_t;
    // Allocated flash/ROM size
    typedef enum logic [1:0] {
        EACSD_ALLOC_0K,
        EACSD_ALLOC_16K,
        EACSD_ALLOC_48K,
        EACSD_ALLOC_64K
    } eacsd_alloc_t;
endpackage : eacsd_pkg

// [rtl/eacsd_page_classify.sv]
/*
 Classifies a page window access as internal or external.
 Assumes page index and switches are stable in the current bus cycle.
*/
`timescale 1ns/10ps
`include "eacsd_defines.svh"

module eacsd_page_classify
    import eacsd_pkg::*;
(
    input wire logic [5:0] pageIndexBits,
    input wire logic [1:0] pagingConfigSwitches,
    output logic pageInternal
);
    // Pure comparison so the answer lands in the same cycle
    always_comb begin
        unique case (pagingConfigSwitches)
            2'h0: pageInternal = (pageIndexBits >= `EACSD_PIX_SW00);
            2'h1: pageInternal = (pageIndexBits >= `EACSD_PIX_SW01);
            2'h2: pageInternal = (pageIndexBits >= `EACSD_PIX_SW10);
            2'h3: pageInternal = 1'b1;
        endcase
    end
endmodule : eacsd_page_classify

// [rtl/eacsd_decode.sv]
/*
 Extended address and emulation chip select decode onto port K.
 The six extended address lines carry the page index inside the
 program page window and a fixed code per 16K region elsewhere; the
 active-low chip select follows the allocated flash/ROM size, the
 accessed region, the high-map bit and the page window classification.
 All outputs are registered, so they trail the bus cycle by one clock.
 Bit 6 of port K is never taken over and always follows GPIO.
 Assumes all inputs come from logic in the ref_clk domain, so no
 synchronisers are placed; port K pins are driven by a pad wrapper.
 Assumes the address and page index are stable for a whole bus cycle,
 one clock ref_clk and a synchronous active-high reset.
*/
// Notes on behaviour
// - In window with enable and expanded mode, page index goes out.
// - Extended address bits 5..0 sit on port K bits 5..0.
// - Outside window drive 0x3D, 0x3E or 0x3F by 16K region.
// - Address outputs appear only with enable set and expanded mode.
// - Chip select active low, by allocation, region, and high-map bit.
// - 0K: high below 0x8000, low for window and top region.
// - 16K: low only for top region.
// - 48K: low bottom high; mid follows map bit; window internal low.
// - 64K: both low regions follow map bit; window internal low.
// - Internal pages depend on switches: 0x38, 0x30, 0x20 up, or all.
// - Enable makes port K bit 7 the chip select, else GPIO.
`timescale 1ns/10ps
`include "eacsd_defines.svh"

module eacsd_decode
    import eacsd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [15:0] cpuAddr,
    input wire logic [5:0] programPageRegister,
    input wire logic [1:0] pagingConfigSwitches,
    input wire logic [1:0] allocSize,
    input wire logic romHighMapCtl,
    input wire logic emulPortkEnable,
    input wire logic expandedMode,
    input wire logic [7:0] gpioOut,
    input wire logic [7:0] gpioOe,
    output logic [7:0] portkOut,
    output logic [7:0] portkOe,
    output logic [5:0] extendedAddrHi,
    output logic emulChipSelectN,
    output logic pageInternal
);
    // Decoded views of the bus cycle
    eacsd_region_t region;
    eacsd_alloc_t alloc;
    logic pageInt;
    logic [5:0] xaComb;
    logic csComb;
    logic active;

    // Output registers and their next values
    logic [7:0] portkOut_reg;
    logic [7:0] portkOut_next;
    logic [7:0] portkOe_reg;
    logic [7:0] portkOe_next;
    logic [5:0] xa_reg;
    logic [5:0] xa_next;
    logic cs_reg;
    logic cs_next;
    logic pint_reg;
    logic pint_next;

    eacsd_page_classify u_classify (
        .pageIndexBits(programPageRegister),
        .pagingConfigSwitches(pagingConfigSwitches),
        .pageInternal(pageInt)
    );

    // Region and allocation views of the raw inputs
    assign region = eacsd_region_t'(
        cpuAddr[`EACSD_REGION_HI:`EACSD_REGION_LO]);
    assign alloc = eacsd_alloc_t'(allocSize);

    // Decode takes over port K bits 5..0 only with enable and expanded mode
    assign active = emulPortkEnable & expandedMode;

    // Extended address code for the current bus cycle; only the window
    // passes the page through, every other region has its own code
    always_comb begin
        unique case (region)
            EACSD_REG_LOW: begin
                xaComb = `EACSD_XA_LOW;
            end
            EACSD_REG_MID: begin
                xaComb = `EACSD_XA_MID;
            end
            EACSD_REG_WIN: begin
                xaComb = programPageRegister;
            end
            EACSD_REG_TOP: begin
                xaComb = `EACSD_XA_TOP;
            end
        endcase
    end

    // Chip select for the current bus cycle, per allocation; the
    // high-map bit only matters for the two largest allocations
    always_comb begin
        // Chip select is active low; 1 means idle
        csComb = 1'b1;
        unique case (alloc)
            // Nothing allocated: emulator answers window and top region
            EACSD_ALLOC_0K: begin
                csComb = !(region == EACSD_REG_WIN ||
                           region == EACSD_REG_TOP);
            end
            // Only the top region is emulated
            EACSD_ALLOC_16K: begin
                csComb = !(region == EACSD_REG_TOP);
            end
            // Mid region follows the map bit; window follows page class
            EACSD_ALLOC_48K: begin
                unique case (region)
                    EACSD_REG_LOW: csComb = 1'b1;
                    EACSD_REG_MID: csComb = romHighMapCtl;
                    EACSD_REG_WIN: csComb = !pageInt;
                    EACSD_REG_TOP: csComb = 1'b0;
                endcase
            end
            // Both low regions follow the map bit
            EACSD_ALLOC_64K: begin
                unique case (region)
                    EACSD_REG_LOW: csComb = romHighMapCtl;
                    EACSD_REG_MID: csComb = romHighMapCtl;
                    EACSD_REG_WIN: csComb = !pageInt;
                    EACSD_REG_TOP: csComb = 1'b0;
                endcase
            end
        endcase
    end

    // Extended address group; the fixed code while idle keeps the far
    // side from ever seeing a stale page on a deselected bus
    always_comb begin
        xa_next = `EACSD_XA_LOW;
        if (active) begin
            xa_next = xaComb;
        end
    end

    // Extended address register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            xa_reg <= `EACSD_XA_LOW;
        end else begin
            xa_reg <= xa_next;
        end
    end

    // Chip select group; idle is high so no memory answers by accident
    always_comb begin
        cs_next = 1'b1;
        if (active) begin
            cs_next = csComb;
        end
    end

    // Chip select register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cs_reg <= 1'b1;
        end else begin
            cs_reg <= cs_next;
        end
    end

    // Window classification seen from outside, only for window accesses
    always_comb begin
        pint_next = 1'b0;
        if (region == EACSD_REG_WIN) begin
            pint_next = pageInt;
        end
    end

    // Classification register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pint_reg <= 1'b0;
        end else begin
            pint_reg <= pint_next;
        end
    end

    // Port K pin group; GPIO owns every bit that the decode does not
    // take over, and bit 6 always stays with GPIO
    always_comb begin
        portkOut_next = gpioOut;
        portkOe_next = gpioOe;
        if (active) begin
            // Page or fixed code goes out on the low six pins
            portkOut_next[`EACSD_XA_W-1:0] = xaComb;
            portkOe_next[`EACSD_XA_W-1:0] = {`EACSD_XA_W{1'b1}};
        end
        if (emulPortkEnable) begin
            // Chip select idles high outside expanded mode
            portkOut_next[`EACSD_CS_BIT] = cs_next;
            portkOe_next[`EACSD_CS_BIT] = 1'b1;
        end
    end

    // Port K registers; outputs must come from flops, which costs one
    // cycle of latency against the bus cycle that caused them
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            portkOut_reg <= `EACSD_PORTK_RST;
            portkOe_reg <= `EACSD_PORTK_OE_RST;
        end else begin
            portkOut_reg <= portkOut_next;
            portkOe_reg <= portkOe_next;
        end
    end

    // Top-level outputs come straight from the registers
    assign portkOut = portkOut_reg;
    assign portkOe = portkOe_reg;
    assign extendedAddrHi = xa_reg;
    assign emulChipSelectN = cs_reg;
    assign pageInternal = pint_reg;
endmodule : eacsd_decode

// [bench/eacsd_props.sv]
/* Port checker for eacsd_decode, bound below.
   Assumes outputs trail inputs by one ref_clk edge. */
`timescale 1ns/10ps
module eacsd_props (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [15:0] cpuAddr,
    input wire logic [5:0] programPageRegister,
    input wire logic [1:0] pagingConfigSwitches,
    input wire logic [1:0] allocSize,
    input wire logic romHighMapCtl,
    input wire logic emulPortkEnable,
    input wire logic expandedMode,
    input wire logic [7:0] portkOut,
    input wire logic [5:0] extendedAddrHi,
    input wire logic emulChipSelectN,
    input wire logic pageInternal
);
    logic vReg;
    wire logic a = emulPortkEnable & expandedMode;
    wire logic [1:0] rg = cpuAddr[15:14];
    // First edge after reset still shows reset values, so skip it
    always_ff @(posedge ref_clk) vReg <= !reset;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    a_window_page: assert property (vReg && $past(a && rg == 2) |->
        extendedAddrHi == $past(programPageRegister)) else $error("xa page");
    a_xa_pins: assert property (vReg && $past(a) |->
        portkOut[5:0] == extendedAddrHi) else $error("pins 5:0");
    a_fixed_code: assert property (vReg && $past(a && rg != 2) |->
        extendedAddrHi == 6'h3d + $past(rg) - ($past(rg) == 3))
        else $error("fixed code");
    a_idle_safe: assert property (vReg && !$past(a) |->
        emulChipSelectN && extendedAddrHi == 6'h3d) else $error("idle");
    a_top_select: assert property (vReg && $past(a && rg == 3) |->
        !emulChipSelectN) else $error("top cs");
    a_cs_pin: assert property (vReg && $past(a) |->
        portkOut[7] == emulChipSelectN) else $error("pin 7");
    a_map_follow: assert property (vReg && $past(a && allocSize == 3 &&
        !cpuAddr[15]) |-> emulChipSelectN == $past(romHighMapCtl))
        else $error("map bit");
    a_page_ranges: assert property (vReg && $past(a && rg == 2 &&
        pagingConfigSwitches == 0) |-> pageInternal ==
        ($past(programPageRegister) >= 6'h38)) else $error("class");
endmodule : eacsd_props
bind eacsd_decode eacsd_props chk_u (.*);

// [bench/eacsd_ext_mem.sv]
/* External memory stand-in on port K.
   Assumes pin 7 is pulled up when nobody drives it. */
`timescale 1ns/10ps
module eacsd_ext_mem (
    input wire logic [7:0] portkOut,
    input wire logic [7:0] portkOe,
    output logic memSelected
);
    // Only a driven low selects; a released pin floats high
    assign memSelected = portkOe[7] & !portkOut[7];
endmodule : eacsd_ext_mem

// [bench/eacsd_decode_tb.sv]
/* Bench for eacsd_decode with the memory stand-in.
   Assumes rtl/ on the include path. */
`timescale 1ns/10ps
module eacsd_decode_tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic en = 1'b0;
    logic ex = 1'b0;
    logic map = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [5:0] page = 6'h00;
    logic [1:0] sw = 2'h0;
    logic [1:0] alloc = 2'h0;
    logic [7:0] pk;
    logic [7:0] oe;
    logic [5:0] xa;
    logic cs;
    logic sel;
    logic [47:0] r;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    // {en,ex,map,-} addr page sw alloc, then expected xa and cs
    logic [47:0] rows [15] = '{
        48'hc_9000_3a_0_2_3a_0, 48'hc_9000_37_0_2_37_1,
        48'hc_4000_00_0_2_3e_0, 48'he_4000_00_0_2_3e_1,
        48'hc_0000_00_0_3_3d_0, 48'he_1000_00_0_3_3d_1,
        48'hc_ffff_00_0_1_3f_0, 48'hc_a000_05_0_1_05_1,
        48'he_8000_2f_1_0_2f_0, 48'hc_2000_00_0_0_3d_1,
        48'hc_8000_1f_3_3_1f_0, 48'hc_b000_30_1_2_30_0,
        48'hc_b000_1f_2_2_1f_1, 48'h8_c000_00_0_0_3d_1,
        48'h4_c000_00_0_0_3d_1};
    eacsd_decode dut_u (.ref_clk(ref_clk), .reset(reset), .cpuAddr(addr),
        .programPageRegister(page), .pagingConfigSwitches(sw),
        .allocSize(alloc), .romHighMapCtl(map), .emulPortkEnable(en),
        .expandedMode(ex), .gpioOut(8'h55), .gpioOe(8'h40), .portkOut(pk),
        .portkOe(oe), .extendedAddrHi(xa), .emulChipSelectN(cs),
        .pageInternal());
    eacsd_ext_mem mem_u (.portkOut(pk), .portkOe(oe), .memSelected(sel));
    task automatic chk(input string what, input logic [5:0] exp,
        input logic [5:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    initial forever #20 ref_clk = ~ref_clk;
    // Hang guard; the run needs under 50 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 400) begin
            fails++;
            close_out();
        end
    end
    // Reset, table rows, then a reset landing on a selecting access
    initial begin
        repeat (7) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("reset xa", 6'h3d, xa);
        chk("reset cs", 6'h01, {5'h0, cs});
        @(posedge ref_clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            {en, ex, map} <= r[47:45];
            addr <= r[43:28];
            page <= r[25:20];
            sw <= r[17:16];
            alloc <= r[13:12];
            @(posedge ref_clk);
            @(negedge ref_clk);
            chk("xa", r[9:4], xa);
            chk("cs", {5'h0, r[0]}, {5'h0, cs});
            chk("select", {5'h0, !r[0]}, {5'h0, sel});
            chk("pins", r[47:46] == 2'h3 ? r[9:4] : 6'h15, pk[5:0]);
            chk("pin 6", 6'h01, {5'h0, pk[6]});
            @(posedge ref_clk);
        end
        {en, ex, map} <= 3'h6;
        reset <= 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk("mid reset cs", 6'h01, {5'h0, cs});
        close_out();
    end
endmodule : eacsd_decode_tb
